// ===== els_top.sv
// Constants package and register bank top for the E1 startup and LOS block
package els_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_LOS_DET = 12'h004;
    localparam logic [11:0] OFS_LOS_REC = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [11:0] OFS_INT_STAT = 12'h010;
    localparam logic [11:0] OFS_INT_MASK = 12'h014;
    localparam logic [11:0] OFS_TX_FIFO = 12'h018;
    localparam logic [11:0] OFS_HOST_CMD = 12'h01c;
    localparam logic [11:0] OFS_CNT_LATCH = 12'h020;
    localparam logic [11:0] OFS_CNT_VALUE = 12'h024;
    localparam logic [11:0] OFS_MCLK_BASE = 12'h040;
    localparam logic [11:0] OFS_SIG_BASE = 12'h080;
    localparam int MCLK_REGS = 8;
    localparam int SIG_REGS = 16;
    // Control register fields
    localparam int CTRL_STD_BIT = 0;
    localparam int CTRL_DIGITAL_BIT = 1;
    localparam int CTRL_DUAL_RAIL_BIT = 2;
    localparam int CTRL_PRECODE_BIT = 3;
    localparam int CTRL_TXC_LSB = 4;
    localparam int CTRL_RXC_LSB = 6;
    localparam int CTRL_WIDTH = 8;
    // Line code encodings
    localparam logic [1:0] CODE_NRZ = 2'h0;
    localparam logic [1:0] CODE_CMI = 2'h1;
    localparam logic [1:0] CODE_AMI = 2'h2;
    localparam logic [1:0] CODE_HDB3 = 2'h3;
    // Status and interrupt bits
    localparam int ST_LOS_BIT = 0;
    localparam int ST_CODE_ERR_BIT = 1;
    localparam int INT_LOS_SET_BIT = 0;
    localparam int INT_LOS_CLR_BIT = 1;
    localparam int INT_WIDTH = 2;
    // Reset values and LOS scaling
    localparam logic [7:0] LOS_COUNT_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MCLK_RST = 8'h00;
    localparam logic [INT_WIDTH-1:0] INT_MASK_RST = 2'h0;
    localparam int LOS_DET_SHIFT = 4;
    localparam int LOS_CNT_W = 13;
    localparam int EVT_CNT_W = 16;

    // Line configuration handed to the line side
    typedef struct packed {
        logic t1_mode;
        logic digital_if;
        logic dual_rail_select;
        logic cmi_precode;
        logic [1:0] tx_code;
        logic [1:0] rx_code;
    } els_cfg_t;

    // Host write strobe towards the datapath
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [7:0] data;
    } els_wr_t;
endpackage

`timescale 1ns/1ps
module els_top
    import els_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_bit_clk,
    input wire logic line_bit,
    output els_cfg_t line_cfg,
    output logic los,
    output logic irq,
    output els_wr_t tx_fifo_wr,
    output els_wr_t sig_wr,
    output els_wr_t cmd_wr
);
    // Word hit at a base plus a word index
    function automatic logic hit(input logic [11:0] a, input logic [11:0] base, input int n);
        hit = (a[11:2] >= base[11:2]) && ({22'h0, a[11:2]} < ({22'h0, base[11:2]} + n));
    endfunction

    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] det_q, det_d;
    logic [7:0] rec_q, rec_d;
    logic [7:0] mclk_q [MCLK_REGS];
    logic [7:0] mclk_d [MCLK_REGS];
    logic [INT_WIDTH-1:0] ist_q, ist_d;
    logic [INT_WIDTH-1:0] imask_q, imask_d;
    logic [EVT_CNT_W-1:0] evt_q, evt_d;
    logic [EVT_CNT_W-1:0] latch_q, latch_d;
    logic [31:0] rdata_q, rdata_d;
    els_wr_t fifo_q, fifo_d, sig_q, sig_d, cmd_q, cmd_d;
    els_cfg_t cfg_q, cfg_d;
    logic [2:0] clk_sync_q, clk_sync_d;
    logic [1:0] bit_sync_q, bit_sync_d;
    logic wr_en, rd_setup, los_set, los_clr, los_state, code_err;
    logic [3:0] mclk_idx, sig_idx;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mclk_idx = 4'((paddr - OFS_MCLK_BASE) >> 2);
    assign sig_idx = 4'((paddr - OFS_SIG_BASE) >> 2);

    // Zero wait state slave, no error response
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = rdata_q;

    // Line pin synchronisers and bit clock edge
    always_comb
    begin
        clk_sync_d = {clk_sync_q[1:0], line_bit_clk};
        bit_sync_d = {bit_sync_q[0], line_bit};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_sync_q <= 3'h0;
            bit_sync_q <= 2'h0;
        end
        else
        begin
            clk_sync_q <= clk_sync_d;
            bit_sync_q <= bit_sync_d;
        end
    end

    // LOS detector running on recovered bit clock edges
    els_los_det #(
        .CNT_W(LOS_CNT_W)
    ) u_los (
        .pclk(pclk),
        .presetn(presetn),
        .bit_en(clk_sync_q[1] && !clk_sync_q[2]),
        .bit_val(bit_sync_q[1]),
        .detect_count(det_q),
        .recover_count(rec_q),
        .los(los_state),
        .los_set(los_set),
        .los_clr(los_clr)
    );

    // Analog side accepts only AMI and HDB3
    assign code_err = !ctrl_q[CTRL_DIGITAL_BIT] &&
        (!ctrl_q[CTRL_TXC_LSB+1] || !ctrl_q[CTRL_RXC_LSB+1]);

    // Configuration registers and write-only strobes
    always_comb
    begin
        ctrl_d = ctrl_q;
        det_d = det_q;
        rec_d = rec_q;
        imask_d = imask_q;
        mclk_d = mclk_q;
        fifo_d = '0;
        sig_d = '0;
        cmd_d = '0;
        if (wr_en)
        begin
            if (paddr == OFS_CTRL)
                ctrl_d = pwdata[CTRL_WIDTH-1:0];
            if (paddr == OFS_LOS_DET)
                det_d = pwdata[7:0];
            if (paddr == OFS_LOS_REC)
                rec_d = pwdata[7:0];
            if (paddr == OFS_INT_MASK)
                imask_d = pwdata[INT_WIDTH-1:0];
            if (hit(paddr, OFS_MCLK_BASE, MCLK_REGS))
                mclk_d[mclk_idx[2:0]] = pwdata[7:0];
            if (paddr == OFS_TX_FIFO)
                fifo_d = '{valid: 1'b1, index: 4'h0, data: pwdata[7:0]};
            if (hit(paddr, OFS_SIG_BASE, SIG_REGS))
                sig_d = '{valid: 1'b1, index: sig_idx, data: pwdata[7:0]};
            if (paddr == OFS_HOST_CMD)
                cmd_d = '{valid: 1'b1, index: 4'h0, data: pwdata[7:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            det_q <= LOS_COUNT_RST;
            rec_q <= LOS_COUNT_RST;
            imask_q <= INT_MASK_RST;
            for (int i = 0; i < MCLK_REGS; i++)
                mclk_q[i] <= MCLK_RST;
            fifo_q <= '0;
            sig_q <= '0;
            cmd_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            det_q <= det_d;
            rec_q <= rec_d;
            imask_q <= imask_d;
            mclk_q <= mclk_d;
            fifo_q <= fifo_d;
            sig_q <= sig_d;
            cmd_q <= cmd_d;
        end
    end

    // Sticky events, LOS event counter and its latch
    always_comb
    begin
        ist_d = ist_q;
        evt_d = evt_q;
        latch_d = latch_q;
        if (wr_en && paddr == OFS_INT_STAT)
            ist_d = ist_q & ~pwdata[INT_WIDTH-1:0];
        // Set wins over a simultaneous clear
        if (los_set)
            ist_d[INT_LOS_SET_BIT] = 1'b1;
        if (los_clr)
            ist_d[INT_LOS_CLR_BIT] = 1'b1;
        if (wr_en && paddr == OFS_CNT_LATCH)
        begin
            latch_d = evt_q;
            evt_d = '0;
        end
        if (los_set)
            evt_d = evt_d + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_q <= '0;
            evt_q <= '0;
            latch_q <= '0;
        end
        else
        begin
            ist_q <= ist_d;
            evt_q <= evt_d;
            latch_q <= latch_d;
        end
    end

    // Read data captured in the setup phase
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_setup)
        begin
            rdata_d = 32'h0; // Unused and write-only addresses read zero
            if (paddr == OFS_CTRL)
                rdata_d[CTRL_WIDTH-1:0] = ctrl_q;
            if (paddr == OFS_LOS_DET)
                rdata_d[7:0] = det_q;
            if (paddr == OFS_LOS_REC)
                rdata_d[7:0] = rec_q;
            if (paddr == OFS_STATUS)
            begin
                rdata_d[ST_LOS_BIT] = los_state;
                rdata_d[ST_CODE_ERR_BIT] = code_err;
            end
            if (paddr == OFS_INT_STAT)
                rdata_d[INT_WIDTH-1:0] = ist_q;
            if (paddr == OFS_INT_MASK)
                rdata_d[INT_WIDTH-1:0] = imask_q;
            if (paddr == OFS_CNT_VALUE)
                rdata_d[EVT_CNT_W-1:0] = latch_q;
            if (hit(paddr, OFS_MCLK_BASE, MCLK_REGS))
                rdata_d[7:0] = mclk_q[mclk_idx[2:0]];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= 32'h0;
        else
            rdata_q <= rdata_d;
    end

    // Registered line configuration outputs
    always_comb
    begin
        cfg_d.t1_mode = ctrl_q[CTRL_STD_BIT];
        cfg_d.digital_if = ctrl_q[CTRL_DIGITAL_BIT];
        cfg_d.dual_rail_select = ctrl_q[CTRL_DUAL_RAIL_BIT];
        cfg_d.cmi_precode = ctrl_q[CTRL_PRECODE_BIT];
        cfg_d.tx_code = ctrl_q[CTRL_TXC_LSB +: 2];
        cfg_d.rx_code = ctrl_q[CTRL_RXC_LSB +: 2];
        // Analog interface falls back to HDB3 on an illegal code
        if (!ctrl_q[CTRL_DIGITAL_BIT])
        begin
            if (!ctrl_q[CTRL_TXC_LSB+1])
                cfg_d.tx_code = CODE_HDB3;
            if (!ctrl_q[CTRL_RXC_LSB+1])
                cfg_d.rx_code = CODE_HDB3;
            cfg_d.cmi_precode = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_q <= '0;
        else
            cfg_q <= cfg_d;
    end

    assign line_cfg = cfg_q;
    assign los = los_state;
    assign irq = |(ist_q & imask_q);
    assign tx_fifo_wr = fifo_q;
    assign sig_wr = sig_q;
    assign cmd_wr = cmd_q;
endmodule

// ===== els_los_det.sv
// Loss-of-signal detection and recovery counter
`timescale 1ns/1ps
module els_los_det
    import els_pkg::*;
#(
    parameter int CNT_W = 13
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_en,
    input wire logic bit_val,
    input wire logic [7:0] detect_count,
    input wire logic [7:0] recover_count,
    output logic los,
    output logic los_set,
    output logic los_clr
);
    logic [CNT_W-1:0] zero_q, zero_d, win_q, win_d, ones_q, ones_d;
    logic [CNT_W-1:0] det_thr, rec_thr;
    logic los_q, los_d, set_q, set_d, clr_q, clr_d;

    // Interval is (count+1)*16 bits, recovery needs count+1 ones
    assign det_thr = (CNT_W'(detect_count) + CNT_W'(1)) << LOS_DET_SHIFT;
    assign rec_thr = CNT_W'(recover_count) + CNT_W'(1);

    // Zero run, recovery window and ones counting
    always_comb
    begin
        zero_d = zero_q;
        win_d = win_q;
        ones_d = ones_q;
        los_d = los_q;
        set_d = 1'b0;
        clr_d = 1'b0;
        if (bit_en)
        begin
            if (bit_val)
                zero_d = '0;
            else if (zero_q != det_thr)
                zero_d = zero_q + 1'b1;
            if (!los_q && !bit_val && (zero_q + 1'b1 == det_thr))
            begin
                los_d = 1'b1;
                set_d = 1'b1;
                win_d = '0;
                ones_d = '0;
            end
            else if (los_q)
            begin
                ones_d = ones_q + CNT_W'(bit_val);
                win_d = win_q + 1'b1;
                if (ones_d >= rec_thr)
                begin
                    los_d = 1'b0;
                    clr_d = 1'b1;
                    zero_d = '0;
                end
                if (win_d == det_thr || !los_d)
                begin
                    win_d = '0;
                    ones_d = '0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zero_q <= '0;
            win_q <= '0;
            ones_q <= '0;
            los_q <= 1'b0;
            set_q <= 1'b0;
            clr_q <= 1'b0;
        end
        else
        begin
            zero_q <= zero_d;
            win_q <= win_d;
            ones_q <= ones_d;
            los_q <= los_d;
            set_q <= set_d;
            clr_q <= clr_d;
        end
    end

    assign los = los_q;
    assign los_set = set_q;
    assign los_clr = clr_q;
endmodule

// ===== els_line_src.sv
// Line side model: recovered bit clock and received bit
`timescale 1ns/1ps
module els_line_src
(
    input wire logic pclk,
    output logic line_bit_clk,
    output logic line_bit
);
    // Bit clock idles low between bursts
    initial
    begin
        line_bit_clk = 1'b0;
        line_bit = 1'b0;
    end

    // Send n copies of one bit, nine bus clocks a bit, well under a quarter rate
    task automatic send(input logic b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            line_bit <= b;
            repeat (4) @(posedge pclk);
            line_bit_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            line_bit_clk <= 1'b0;
        end
        // Released line shows the opposite level
        @(posedge pclk);
        line_bit <= ~b;
    endtask
endmodule

// ===== els_top_properties.sv
// Port checker for the E1 startup and LOS register bank
`timescale 1ns/1ps
module els_top_properties
    import els_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic line_bit_clk,
    input wire els_cfg_t line_cfg,
    input wire logic los,
    input wire els_wr_t sig_wr,
    input wire els_wr_t cmd_wr,
    input wire els_wr_t tx_fifo_wr
);
    logic [7:0] det_q;
    logic [7:0] rec_q;
    logic lbc_q;
    logic [3:0] age_q;
    logic wr;
    logic rd;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Access phase of a write, setup of a read
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // Shadow LOS counts and age of the last bit clock edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            det_q <= 8'h00;
            rec_q <= 8'h00;
            lbc_q <= 1'b0;
            age_q <= 4'hf;
        end
        else
        begin
            if (wr && paddr == OFS_LOS_DET)
                det_q <= pwdata[7:0];
            if (wr && paddr == OFS_LOS_REC)
                rec_q <= pwdata[7:0];
            lbc_q <= line_bit_clk;
            if (line_bit_clk && !lbc_q)
                age_q <= 4'h0;
            else if (age_q != 4'hf)
                age_q <= age_q + 4'h1;
        end
    end

    a_t1_mode_follow: assert property (wr && paddr == OFS_CTRL
        |-> ##3 line_cfg.t1_mode == $past(pwdata[CTRL_STD_BIT], 3))
        else $error("standard select not applied");
    a_det_readback: assert property (rd && paddr == OFS_LOS_DET
        |=> prdata == {24'h000000, det_q})
        else $error("detect count readback wrong");
    a_rec_readback: assert property (rd && paddr == OFS_LOS_REC
        |=> prdata == {24'h000000, rec_q})
        else $error("recover count readback wrong");
    a_unused_zero: assert property (rd && paddr == 12'h0fc |=> prdata == 32'h0)
        else $error("unused address read not zero");
    a_wo_read_zero: assert property (rd && (paddr == OFS_TX_FIFO
        || paddr == OFS_HOST_CMD || paddr == OFS_CNT_LATCH) |=> prdata == 32'h0)
        else $error("write-only register read not zero");
    a_sig_strobe: assert property (wr && paddr[11:6] == 6'h02
        |=> sig_wr.valid && sig_wr.index == $past(paddr[5:2]) ##1 !sig_wr.valid)
        else $error("signalling strobe wrong");
    a_cmd_strobe: assert property (wr && paddr == OFS_HOST_CMD
        |=> cmd_wr.valid && cmd_wr.data == $past(pwdata[7:0]))
        else $error("command strobe wrong");
    a_fifo_strobe: assert property (wr && paddr == OFS_TX_FIFO
        |=> tx_fifo_wr.valid && tx_fifo_wr.data == $past(pwdata[7:0]) ##1 !tx_fifo_wr.valid)
        else $error("transmit fifo strobe wrong");
    a_los_from_line: assert property ($changed(los) |-> age_q < 4'hc)
        else $error("loss of signal changed without a line bit");
endmodule

bind els_top els_top_properties u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .line_bit_clk(line_bit_clk), .line_cfg(line_cfg), .los(los), .sig_wr(sig_wr),
    .cmd_wr(cmd_wr), .tx_fifo_wr(tx_fifo_wr));

// ===== els_top_tb.sv
// Self-checking bench for the E1 startup and LOS register bank
`timescale 1ns/1ps
module els_top_tb;
    import els_pkg::*;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, line_bit_clk, line_bit, los, irq;
    els_cfg_t line_cfg;
    int fails, checks_done;

    els_top dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_bit_clk(line_bit_clk), .line_bit(line_bit),
        .line_cfg(line_cfg), .los(los), .irq(irq), .tx_fifo_wr(), .sig_wr(), .cmd_wr());
    els_line_src src(.pclk(pclk), .line_bit_clk(line_bit_clk), .line_bit(line_bit));

    // Bus clock, 50 ns
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One bus transfer: setup, then access until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait states end only by ready or by the watchdog
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        check("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat);
        repeat (3) @(posedge pclk);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(nm, exp, q);
    endtask

    task automatic line(input logic b, input int n);
        src.send(b, n);
        repeat (8) @(posedge pclk);
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl", OFS_CTRL, 32'h0);
        rd_chk("los_det", OFS_LOS_DET, 32'h0);
        rd_chk("los_rec", OFS_LOS_REC, 32'h0);
        rd_chk("int_mask", OFS_INT_MASK, 32'h0);
        $display("test reset done");
        for (int i = 0; i < MCLK_REGS; i++)
        begin
            wr(OFS_MCLK_BASE + 12'(4 * i), 32'h31 + 32'(i));
            rd_chk("mclk", OFS_MCLK_BASE + 12'(4 * i), 32'h31 + 32'(i));
        end
        wr(OFS_LOS_DET, 32'h0a);
        rd_chk("los_det", OFS_LOS_DET, 32'h0a);
        wr(OFS_LOS_REC, 32'h15);
        rd_chk("los_rec", OFS_LOS_REC, 32'h15);
        wr(OFS_TX_FIFO, 32'ha5);
        wr(OFS_HOST_CMD, 32'h5a);
        wr(OFS_SIG_BASE + 12'h03c, 32'h0f);
        wr(12'h030, 32'h0);
        rd_chk("tx_fifo", OFS_TX_FIFO, 32'h0);
        rd_chk("host_cmd", OFS_HOST_CMD, 32'h0);
        rd_chk("cnt_latch", OFS_CNT_LATCH, 32'h0);
        rd_chk("sig", OFS_SIG_BASE + 12'h03c, 32'h0);
        rd_chk("unused", 12'h0fc, 32'h0);
        $display("test access done");
        wr(OFS_CTRL, 32'h01);
        check("t1_mode", 32'h1, {31'h0, line_cfg.t1_mode});
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_CTRL, 32'(c * 80) + 32'h0e);
            check("tx_code", 32'(c), {30'h0, line_cfg.tx_code});
            // Digital, dual rail, precode, same code both ways
            check("dig_cfg", {24'h0, 4'h7, 4'(c * 5)}, {24'h0, line_cfg});
            rd_chk("dig_status", OFS_STATUS, 32'h0);
            wr(OFS_CTRL, 32'(c * 80));
            // Analog forces HDB3 for NRZ and CMI, precode off
            check("ana_cfg", {24'h0, 4'h0, (c < 2) ? {CODE_HDB3, CODE_HDB3} : 4'(c * 5)},
                {24'h0, line_cfg});
            rd_chk("ana_status", OFS_STATUS, (c < 2) ? 32'h2 : 32'h0);
        end
        check("e1_mode", 32'h0, {31'h0, line_cfg.t1_mode});
        $display("test modes done");
        wr(OFS_INT_MASK, 32'h3);
        line(1'b0, 170);
        line(1'b1, 1);
        line(1'b0, 175);
        check("los_175", 32'h0, {31'h0, los});
        line(1'b0, 1);
        check("los_176", 32'h1, {31'h0, los});
        check("irq_set", 32'h1, {31'h0, irq});
        rd_chk("int_stat", OFS_INT_STAT, 32'h1);
        wr(OFS_INT_STAT, 32'h1);
        check("irq_clr", 32'h0, {31'h0, irq});
        line(1'b1, 21);
        check("los_21", 32'h1, {31'h0, los});
        line(1'b1, 1);
        check("los_22", 32'h0, {31'h0, los});
        rd_chk("int_stat", OFS_INT_STAT, 32'h2);
        check("irq_rec", 32'h1, {31'h0, irq});
        $display("test los done");
        wr(OFS_SIG_BASE + 12'h004, 32'h3c);
        wr(OFS_CNT_LATCH, 32'h0);
        rd_chk("cnt_value", OFS_CNT_VALUE, 32'h1);
        wr(OFS_CNT_LATCH, 32'h0);
        rd_chk("cnt_value0", OFS_CNT_VALUE, 32'h0);
        // Reset again in mid-run: programmed counts must go back to zero
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("los_det_rst", OFS_LOS_DET, 32'h0);
        rd_chk("los_rec_rst", OFS_LOS_REC, 32'h0);
        check("los_rst", 32'h0, {31'h0, los});
        check("irq_rst", 32'h0, {31'h0, irq});
        $display("test latch and reset done");
        print_verdict();
    end

    // Watchdog: the tests take about 3650 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end
endmodule
